// ---- design/adio_pkg.sv ----
// Constants, types and register map of the auxiliary digital I/O port
// Summary of operation
// - Three input levels readable one by index, or all when index is zero
// - Rising and falling edge of each input separately enabled, pulse an action
// - New level must hold for filter time, 0 to 1000 ms, before an event
// - Filter time zero raises the edge event at once
// - Filter times reset to zero
// - Two outputs, each selecting low, high or one of six status sources
// - Output enabled, single phase phase_flag_a and fault each drive one
// - Transient active, program running and remote mode each drive one
// - Polarity bit one inverts the selected source before the pin
// - Software reads back the level actually driven on each output pin
// - Remote enable bit is writable and readable
// - Remote inhibit bit is writable and readable
// - Relay change strobe option pulses the function strobe on relay change
// - Program change strobe option pulses the strobe on setting change
// - Transient strobe option pulses the strobe when a transient starts
package adio_pkg;
  localparam int          NUM_IN     = 3;
  localparam int          NUM_OUT    = 2;
  localparam int          FILT_W     = 10;
  localparam logic [9:0]  FILT_MAX   = 10'h3E8;
  localparam logic [9:0]  FILT_RST   = 10'h000;
  localparam int          CLK_NS     = 10;
  localparam int          TICK_NS    = 1000000;
  localparam int          TICK_CYC   = TICK_NS / CLK_NS;
  localparam int          TICK_W     = 17;

  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_IN_LVL  = 8'h04;
  localparam logic [7:0] OFS_IN_IDX  = 8'h08;
  localparam logic [7:0] OFS_FILT0   = 8'h0C;
  localparam logic [7:0] OFS_OUT_CFG = 8'h18;
  localparam logic [7:0] OFS_OUT_LVL = 8'h1C;
  localparam logic [7:0] OFS_IRQ_STS = 8'h20;
  localparam logic [7:0] OFS_IRQ_MSK = 8'h24;
  localparam logic [7:0] OFS_EDGE_EN = 8'h28;

  localparam int B_REM_EN  = 0;
  localparam int B_REM_INH = 1;
  localparam int B_STB_REL = 4;
  localparam int B_STB_PRG = 5;
  localparam int B_STB_TRN = 6;
  localparam int OCFG_STRIDE = 8;
  localparam int OCFG_INV  = 4;
  localparam int IRQ_FALL  = 3;
  localparam int IRQ_STB   = 6;

  localparam logic [6:0]  CTRL_RST   = 7'h00;
  localparam logic [15:0] OCFG_RST   = 16'h0302;
  localparam logic [6:0]  EDGE_RST   = 7'h00;
  localparam logic [6:0]  IRQ_RST    = 7'h00;

  typedef enum logic [2:0] {
    ADIO_SRC_LOW, ADIO_SRC_HIGH, ADIO_SRC_OUTEN, ADIO_SRC_PHASE_FLAG_A,
    ADIO_SRC_FAULT, ADIO_SRC_TRANS, ADIO_SRC_PROG, ADIO_SRC_REMOTE
  } adio_src_t;

  typedef struct packed {
    logic out_enabled;
    logic phase_flag_a;
    logic fault;
    logic transient_active;
    logic program_running;
    logic remote_mode;
  } adio_status_t;

  typedef struct packed {
    logic relay_change;
    logic program_change;
    logic transient_start;
  } adio_trig_t;

  typedef struct packed {
    logic [NUM_IN-1:0]             s1;
    logic [NUM_IN-1:0]             s2;
    logic [NUM_IN-1:0]             s3;
    logic [NUM_IN-1:0]             lvl;
    logic [NUM_IN-1:0][FILT_W-1:0] cnt;
    logic [NUM_IN-1:0][FILT_W-1:0] filt;
    logic [TICK_W-1:0]             tick_cnt;
    logic                          tick;
    logic [6:0]                    ctrl;
    logic [1:0]                    idx;
    logic [15:0]                   ocfg;
    logic [6:0]                    edge_en;
    logic [6:0]                    sts;
    logic [6:0]                    msk;
    logic [NUM_OUT-1:0]            dout;
    logic [NUM_IN-1:0]             rise;
    logic [NUM_IN-1:0]             fall;
    logic                          strobe;
    logic                          irq;
    logic                          pready;
    logic                          pslverr;
    logic [31:0]                   prdata;
  } adio_state_t;
endpackage : adio_pkg

// ---- design/adio_port.sv ----
// APB controlled auxiliary digital I/O port with filtered inputs
`timescale 1ns/1ps
module adio_port
  import adio_pkg::*;
#(
  parameter int TICK_CYCLES = TICK_CYC
) (
  input  wire logic               pclk,
  input  wire logic               presetn,
  input  wire logic               psel,
  input  wire logic               penable,
  input  wire logic               pwrite,
  input  wire logic [7:0]         paddr,
  input  wire logic [31:0]        pwdata,
  output logic      [31:0]        prdata,
  output logic                    pready,
  output logic                    pslverr,
  input  wire logic [NUM_IN-1:0]  din,
  input  wire adio_status_t       status,
  input  wire adio_trig_t         trig,
  output logic      [NUM_OUT-1:0] dout,
  output logic      [NUM_IN-1:0]  rise_action,
  output logic      [NUM_IN-1:0]  fall_action,
  output logic                    func_strobe,
  output logic                    remote_enable,
  output logic                    remote_inhibit,
  output logic                    irq
);

  adio_state_t r;
  adio_state_t next_r;

  function automatic logic src_level(input adio_src_t s,
                                     input adio_status_t st);
    logic v;
    v = 1'b0;
    unique case (s)
      ADIO_SRC_LOW:    v = 1'b0;
      ADIO_SRC_HIGH:   v = 1'b1;
      ADIO_SRC_OUTEN:  v = st.out_enabled;
      ADIO_SRC_PHASE_FLAG_A:   v = st.phase_flag_a;
      ADIO_SRC_FAULT:  v = st.fault;
      ADIO_SRC_TRANS:  v = st.transient_active;
      ADIO_SRC_PROG:   v = st.program_running;
      ADIO_SRC_REMOTE: v = st.remote_mode;
    endcase
    return v;
  endfunction : src_level

  function automatic logic is_filt(input logic [7:0] a,
                                   output logic [1:0] n);
    logic hit;
    hit = 1'b0;
    n   = 2'h0;
    for (int i = 0; i < NUM_IN; i++) begin
      if (a == OFS_FILT0 + 8'(4 * i)) begin
        hit = 1'b1;
        n   = 2'(i);
      end
    end
    return hit;
  endfunction : is_filt

  always_comb begin
    logic              wr;
    logic              setup;
    logic              fhit;
    logic [1:0]        fn;
    logic [6:0]        ev;
    logic [FILT_W-1:0] nc;
    logic [7:0]        oc;
    next_r = r;
    wr     = psel && penable && r.pready && pwrite;
    setup  = psel && !penable;
    fhit   = is_filt(paddr, fn);
    ev     = 7'h00;
    nc     = '0;
    oc     = 8'h00;

    // Millisecond tick shared by all three filters
    next_r.tick = 1'b0;
    if (r.tick_cnt == TICK_W'(TICK_CYCLES - 1)) begin
      next_r.tick_cnt = '0;
      next_r.tick     = 1'b1;
    end else begin
      next_r.tick_cnt = r.tick_cnt + 1'b1;
    end

    // Only s2 and s3 are compared; s1 may be metastable
    next_r.s1 = din;
    next_r.s2 = r.s1;
    next_r.s3 = r.s2;
    next_r.rise = '0;
    next_r.fall = '0;
    for (int i = 0; i < NUM_IN; i++) begin
      nc = r.cnt[i] + 1'b1;
      if (r.s2[i] == r.s3[i] && r.s3[i] != r.lvl[i]) begin
        if (r.filt[i] == '0) begin
          next_r.lvl[i] = r.s3[i];
          next_r.cnt[i] = '0;
        end else if (r.tick) begin
          if (nc >= r.filt[i]) begin
            next_r.lvl[i] = r.s3[i];
            next_r.cnt[i] = '0;
          end else begin
            next_r.cnt[i] = nc;
          end
        end
      end else if (r.s3[i] == r.lvl[i]) begin
        // A pulse shorter than the filter restarts the hold count
        next_r.cnt[i] = '0;
      end
      if (next_r.lvl[i] != r.lvl[i]) begin
        next_r.rise[i] = next_r.lvl[i] & r.edge_en[i];
        next_r.fall[i] = ~next_r.lvl[i] & r.edge_en[i + 4];
        ev[i]            = next_r.lvl[i] & r.edge_en[i];
        ev[i + IRQ_FALL] = ~next_r.lvl[i] & r.edge_en[i + 4];
      end
    end

    // Function strobe from the three enabled triggers
    next_r.strobe = (trig.relay_change    && r.ctrl[B_STB_REL]) ||
                    (trig.program_change  && r.ctrl[B_STB_PRG]) ||
                    (trig.transient_start && r.ctrl[B_STB_TRN]);
    ev[IRQ_STB] = next_r.strobe;

    for (int k = 0; k < NUM_OUT; k++) begin
      oc = r.ocfg[k * OCFG_STRIDE +: 8];
      next_r.dout[k] = src_level(adio_src_t'(oc[2:0]), status)
                       ^ oc[OCFG_INV];
    end

    // APB: no wait state, answer registered during setup
    next_r.pready  = setup;
    next_r.pslverr = 1'b0;
    if (setup) begin
      next_r.prdata  = 32'h0000_0000;
      next_r.pslverr = 1'b0;
      unique case (paddr)
        OFS_CTRL:    next_r.prdata = {25'h0, r.ctrl};
        OFS_IN_LVL:  next_r.prdata = {29'h0, r.s3};
        OFS_IN_IDX: begin
          if (r.idx == 2'h0) begin
            next_r.prdata = {29'h0, r.s3};
          end else begin
            next_r.prdata = {28'h0, r.idx, 1'b0,
                             r.s3[r.idx - 2'h1]};
          end
        end
        OFS_OUT_CFG: next_r.prdata = {16'h0, r.ocfg};
        OFS_OUT_LVL: next_r.prdata = {30'h0, r.dout};
        OFS_IRQ_STS: next_r.prdata = {25'h0, r.sts};
        OFS_IRQ_MSK: next_r.prdata = {25'h0, r.msk};
        OFS_EDGE_EN: next_r.prdata = {25'h0, r.edge_en};
        default: begin
          if (fhit) begin
            next_r.prdata = {22'h0, r.filt[fn]};
          end else begin
            next_r.pslverr = 1'b1;
          end
        end
      endcase
    end
    // Error response stands only in the access cycle, beside pready

    if (wr) begin
      unique case (paddr)
        OFS_CTRL:    next_r.ctrl = pwdata[6:0];
        OFS_IN_IDX: begin
          // Index 0 selects all, 1 to 3 a single input
          next_r.idx = pwdata[1:0];
        end
        OFS_OUT_CFG: next_r.ocfg = pwdata[15:0] & 16'h1F1F;
        OFS_IRQ_STS: next_r.sts = r.sts & ~pwdata[6:0];
        OFS_IRQ_MSK: next_r.msk = pwdata[6:0];
        OFS_EDGE_EN: next_r.edge_en = pwdata[6:0] & 7'h77;
        default: begin
          // Out of range filter times saturate at the maximum
          if (fhit) begin
            next_r.filt[fn] = (pwdata[31:10] != '0 ||
                               pwdata[9:0] > FILT_MAX) ?
                              FILT_MAX : pwdata[9:0];
          end
        end
      endcase
    end
    // Set beats a simultaneous write-one-to-clear
    next_r.sts = next_r.sts | ev;
    next_r.irq = |(next_r.sts & next_r.msk);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      r          <= '0;
      r.filt     <= {NUM_IN{FILT_RST}};
      r.ctrl     <= CTRL_RST;
      r.ocfg     <= OCFG_RST;
      r.edge_en  <= EDGE_RST;
      r.sts      <= IRQ_RST;
      r.msk      <= IRQ_RST;
    end else begin
      r <= next_r;
    end
  end

  assign prdata         = r.prdata;
  assign pready         = r.pready;
  assign pslverr        = r.pslverr;
  assign dout           = r.dout;
  assign rise_action    = r.rise;
  assign fall_action    = r.fall;
  assign func_strobe    = r.strobe;
  assign remote_enable  = r.ctrl[B_REM_EN];
  assign remote_inhibit = r.ctrl[B_REM_INH];
  assign irq            = r.irq;

endmodule : adio_port

// ---- dv/adio_pins.sv ----
// Model of the switches and status sources wired to the port
`timescale 1ns/1ps
module adio_pins
  import adio_pkg::*;
(
  input  wire logic              pclk,
  output logic      [NUM_IN-1:0] din,
  output adio_status_t           status,
  output adio_trig_t             trig
);
  initial begin
    din = '0;
    status = '0;
    trig = '0;
  end
  // Contacts hold a level; glitches come from holding it too briefly
  task automatic set_din(input logic [NUM_IN-1:0] v);
    @(posedge pclk);
    din <= v;
  endtask : set_din
  task automatic set_status(input adio_status_t v);
    @(posedge pclk);
    status <= v;
  endtask : set_status
  task automatic pulse_trig(input adio_trig_t v);
    @(posedge pclk);
    trig <= v;
    @(posedge pclk);
    trig <= '0;
  endtask : pulse_trig
endmodule : adio_pins

// ---- dv/adio_port_chk.sv ----
// Assertion checker for the digital I/O port
`timescale 1ns/1ps
module adio_port_chk
  import adio_pkg::*;
(
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic              pwrite,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic [NUM_IN-1:0] din,
  input wire adio_trig_t        trig,
  input wire logic [NUM_IN-1:0] rise_action,
  input wire logic [NUM_IN-1:0] fall_action,
  input wire logic              func_strobe,
  input wire logic              remote_enable,
  input wire logic              remote_inhibit
);
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_setup;
    psel && !penable;
  endsequence
  sequence s_access;
    psel && penable;
  endsequence
  property p_rdy_cause;
    s_setup ##1 s_access |-> pready;
  endproperty
  property p_rdy_pulse;
    pready |=> !pready;
  endproperty
  property p_err;
    pslverr |-> pready;
  endproperty
  property p_fs_cause;
    func_strobe |-> $past(|trig);
  endproperty
  property p_rise_hold;
    (rise_action & ~$past(din, 4)) == '0;
  endproperty
  property p_fall_hold;
    (fall_action & $past(din, 4)) == '0;
  endproperty
  property p_no_both;
    (rise_action & fall_action) == '0;
  endproperty
  property p_rem_en;
    $changed(remote_enable) |-> $past(psel && penable && pwrite && pready);
  endproperty
  property p_rem_inh;
    $changed(remote_inhibit) |-> $past(psel && penable && pwrite && pready);
  endproperty
  a_rdy_cause: assert property (p_rdy_cause)
    else $error("pready missing in access");
  a_rdy_pulse: assert property (p_rdy_pulse)
    else $error("pready longer than one cycle");
  a_err: assert property (p_err)
    else $error("pslverr without pready");
  a_fs_cause: assert property (p_fs_cause)
    else $error("strobe without trigger");
  a_rise_hold: assert property (p_rise_hold)
    else $error("rise event on low input");
  a_fall_hold: assert property (p_fall_hold)
    else $error("fall event on high input");
  a_no_both: assert property (p_no_both)
    else $error("rise and fall together");
  a_rem_en: assert property (p_rem_en)
    else $error("remote enable moved without write");
  a_rem_inh: assert property (p_rem_inh)
    else $error("remote inhibit moved without write");
endmodule : adio_port_chk
bind adio_port adio_port_chk i_adio_port_chk (.pclk, .presetn, .psel,
  .penable, .pwrite, .pready, .pslverr, .din, .trig, .rise_action,
  .fall_action, .func_strobe, .remote_enable, .remote_inhibit);

// ---- dv/adio_port_tb_top.sv ----
// Self-checking bench of the digital I/O port
`timescale 1ns/1ps
module adio_port_tb_top
  import adio_pkg::*;
;
  localparam int TK = 10;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready, pslverr, func_strobe, remote_enable, remote_inhibit, irq;
  logic [NUM_IN-1:0] din, rise_action, fall_action;
  logic [NUM_OUT-1:0] dout;
  adio_status_t status;
  adio_trig_t trig;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc = 0;
  always #5 pclk = ~pclk;
  adio_port #(.TICK_CYCLES(TK)) i_adio_port (.pclk, .presetn, .psel,
    .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr, .din,
    .status, .trig, .dout, .rise_action, .fall_action, .func_strobe,
    .remote_enable, .remote_inhibit, .irq);
  adio_pins i_adio_pins (.pclk, .din, .status, .trig);
  task automatic final_report();
    if (error_cnt == 0 && n_compared > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask : final_report
  task automatic chk(input string nm, input logic [31:0] e, g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("BAD %s exp %h got %h", nm, e, g);
    end
  endtask : chk
  // Holds the request until pready is seen at a rising edge
  task automatic apb(input logic w, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask : wr
  task automatic rd(input logic [7:0] a, input string nm, input logic [31:0] x);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h0, q, e);
    chk(nm, x, q);
  endtask : rd
  task automatic t_reset();
    logic [31:0] q;
    logic e;
    rd(OFS_FILT0, "filt0", 32'h0);
    rd(OFS_OUT_CFG, "ocfg", 32'h0302);
    apb(1'b0, 8'hFC, 32'h0, q, e);
    chk("unmapped", 32'h1, {31'h0, e});
  endtask : t_reset
  task automatic t_remote();
    for (int v = 3; v >= 0; v--) begin
      wr(OFS_CTRL, 32'(v));
      rd(OFS_CTRL, "ctrl", 32'(v));
      chk("rem pins", 32'(v), {30'h0, remote_inhibit, remote_enable});
    end
  endtask : t_remote
  task automatic t_out();
    logic [5:0] st;
    logic ex;
    for (int p = 0; p < 2; p++) begin
      for (int s = 0; s < 16; s++) begin
        st = p ? 6'h2A : 6'h15;
        i_adio_pins.set_status(st);
        wr(OFS_OUT_CFG, {16'h0, 8'h03, 3'h0, s[3], 1'b0, s[2:0]});
        ex = (s[2:0] < 2) ? s[0] : st[7 - s[2:0]];
        ex = ex ^ s[3];
        repeat (3) @(posedge pclk);
        chk("dout", {30'h0, st[4], ex}, {30'h0, dout});
        rd(OFS_OUT_LVL, "out lvl", {30'h0, st[4], ex});
      end
    end
  endtask : t_out
  task automatic t_strobe();
    wr(OFS_IRQ_MSK, 32'h40);
    for (int b = 0; b < 3; b++) begin
      wr(OFS_CTRL, 32'h10 << b);
      i_adio_pins.pulse_trig(3'b100 >> b);
      #1 chk("strobe", 32'h1, {31'h0, func_strobe});
      i_adio_pins.pulse_trig(~(3'b100 >> b));
      #1 chk("no strobe", 32'h0, {31'h0, func_strobe});
    end
    repeat (2) @(posedge pclk);
    chk("irq", 32'h1, {31'h0, irq});
    wr(OFS_IRQ_MSK, 32'h0);
    repeat (2) @(posedge pclk);
    chk("irq masked", 32'h0, {31'h0, irq});
    wr(OFS_IRQ_STS, 32'h40);
    rd(OFS_IRQ_STS, "sts", 32'h0);
    wr(OFS_CTRL, 32'h0);
  endtask : t_strobe
  task automatic wt(input logic f, output int n);
    n = 0;
    do begin
      @(posedge pclk);
      #1 n++;
    end while ((f ? fall_action[1] : rise_action[1]) !== 1'b1 && n < 40);
  endtask : wt
  task automatic t_input();
    int n;
    wr(OFS_EDGE_EN, 32'h77);
    i_adio_pins.set_din(3'b010);
    wt(1'b0, n);
    chk("zero filt lat", 32'd4, n);
    rd(OFS_IN_LVL, "in lvl", 32'h2);
    rd(OFS_IRQ_STS, "sts rise", 32'h2);
    wr(OFS_IN_IDX, 32'h2);
    rd(OFS_IN_IDX, "in idx", 32'h9);
    wr(OFS_IN_IDX, 32'h0);
    rd(OFS_IN_IDX, "in all", 32'h2);
    wr(OFS_FILT0 + 8'h04, 32'h2);
    i_adio_pins.set_din(3'b000);
    repeat (5) @(posedge pclk);
    i_adio_pins.set_din(3'b010);
    wt(1'b1, n);
    chk("glitch", 32'd40, n);
    i_adio_pins.set_din(3'b000);
    wt(1'b1, n);
    chk("filt lat", 32'h1, {31'h0, n >= 13 && n <= 26});
    wr(OFS_FILT0, 32'h7FF);
    rd(OFS_FILT0, "filt sat", 32'h3E8);
  endtask : t_input
  always @(posedge pclk) begin
    cyc <= cyc + 1;
    if (cyc == 20000) begin
      error_cnt++;
      final_report();
    end
  end
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_remote();
    t_out();
    t_strobe();
    t_input();
    final_report();
  end
endmodule : adio_port_tb_top
